// ==== include/prx_consts.svh ====
// Purpose: Offsets, field positions and reset values of the status block
// Assumes: 16-bit register addresses, 32-bit register words
// Notes: Included by the design file, host model and bench
`ifndef PRX_CONSTS_SVH
`define PRX_CONSTS_SVH
`define PRX_OFS_EVSRC 16'h4000
`define PRX_OFS_INFO 16'h42D8
`define PRX_OFS_STAT0 16'h8000
`define PRX_OFS_STAT1 16'h8004
`define PRX_OFS_EVCFG 16'h800C
`define PRX_OFS_SCAN 16'h8010
`define PRX_PROX_LSB 24
`define PRX_TBL_LSB 16
`define PRX_BODY_LSB 8
`define PRX_COMP_LSB 16
`define PRX_SAT_LSB 8
`define PRX_CONV_BIT 7
`define PRX_ANY_BIT 0
`define PRX_CSD_BIT 22
`define PRX_EV2_LSB 20
`define PRX_EV0_LSB 16
`define PRX_F0_LSB 30
`define PRX_SP_LSB 0
`define PRX_SP_RST 11'h032
`define PRX_EVSRC_RST 8'h80
`define PRX_SEL_EV2_BT 2'h0
`define PRX_SEL_EV2_CONV 2'h2
`define PRX_SEL_EV0_SAT 2'h2
`define PRX_DEV_ADDR 7'h28
`define PRX_WORD_STEP 16'h0004
`endif

// ==== include/prx_pkg.sv ====
// Purpose: Types shared by the status block and its surroundings
// Assumes: Six sensing phases, 16-bit measurement values
// Notes: Constants live in prx_consts.svh
package prx_pkg;
  typedef struct packed {
    logic [15:0] prox;
    logic [15:0] body;
    logic [15:0] tbl;
    logic [15:0] sat;
    logic [7:0] hyst;
    logic [1:0] deb;
  } prx_limit_s;
  typedef struct packed {
    logic valid;
    logic [2:0] phase;
    logic [15:0] delta;
    logic [15:0] useful;
  } prx_meas_s;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [31:0] data;
  } prx_req_s;
  typedef enum logic [2:0] {
    PRX_IDLE, PRX_RECV, PRX_ACK_RX, PRX_SEND, PRX_ACK_TX
  } prx_i2c_e;
endpackage

// ==== hw/prx_status.sv ====
// Purpose: Status flags, event sources and serial register port
// Assumes: Front end on CLK; SCL/SDA oversampled on LINK_CLK
// Notes: No clock stretching; read data must settle within SCL high
`timescale 1ns/1ps
`include "prx_consts.svh"

// Functional notes
// - Each phase keeps a proximity flag set while its delta beats the limit.
// - Table flags are kept per phase and forced low without proximity.
// - Table decisions use the table limit with hysteresis and debounce.
// - Body flags use the body limit, hysteresis, debounce and prox gating.
// - The second status word shows per phase pending compensation.
// - A phase's saturation flag is set while its signal beats its limit.
// - Disabling saturation sensing freezes the saturation flags.
// - Conversion active runs from scan start to the last result of the phases scanned that period.
// - Bit zero of the second status word is the OR of proximity flags.
// - With the disable bit set a saturated offset keeps pending, no event.
// - Event two source is body/table edges or conversion end.
// - Event zero source is any saturation flag edge.
// - Phase zero scans every, or every fourth, eighth, sixteenth period.
// - Proximity rises set the close event and falls the far event.
// - Reading the event source clears it and releases the pin.
module prx_status #(
  parameter int PHASES = 6,
  parameter logic [6:0] DEV_ADDR = `PRX_DEV_ADDR,
  // Identity values are arbitrary
  parameter logic [7:0] CHIP_ID = 8'hA5,
  parameter logic [7:0] CHIP_REV = 8'h01
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic LINK_CLK,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic HOST_INTERRUPT_PIN_N,
  output logic [PHASES-1:0] SCAN_PHASES,
  input wire prx_pkg::prx_meas_s MEAS,
  input wire prx_pkg::prx_limit_s [PHASES-1:0] LIMITS,
  input wire logic SAT_EN,
  input wire logic SCAN_TICK,
  input wire logic [PHASES-1:0] PHASE_EN,
  input wire logic [PHASES-1:0] COMP_START,
  input wire logic [PHASES-1:0] COMP_DONE,
  input wire logic [PHASES-1:0] OFFSET_SAT
);
  import prx_pkg::*;

  function automatic logic [2:0] deb_step(input logic flag,
      input logic [1:0] cnt, input logic close, input logic far,
      input logic [1:0] deb);
    logic want;
    want = flag ? far : close;
    if (!want) deb_step = {flag, 2'h0};
    else if (cnt == deb) deb_step = {~flag, 2'h0};
    else deb_step = {flag, 2'(cnt + 2'h1)};
  endfunction

  logic rst_m_ff, rst_n_ff, lrst_m_ff, lrst_n_ff;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_m_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_n_ff <= rst_m_ff;
    end
  end
  always_ff @(posedge LINK_CLK or negedge NRST) begin
    if (!NRST) begin
      lrst_m_ff <= 1'b0;
      lrst_n_ff <= 1'b0;
    end else begin
      lrst_m_ff <= 1'b1;
      lrst_n_ff <= lrst_m_ff;
    end
  end

  // Link side: oversampled serial slave
  logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff;
  prx_i2c_e st_ff, nxt_st;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic oe_n_ff, nxt_oe, rw_ff, nxt_rw, tgl_ff, nxt_tgl;
  logic [1:0] ph_ff, nxt_ph, wb_ff, nxt_wb;
  logic [15:0] adr_ff, nxt_adr;
  logic [31:0] wd_ff, nxt_wd, rdata_ff;
  prx_req_s req_ff, nxt_req;
  wire scl_rise = scl_s_ff && !scl_d_ff;
  wire scl_fall = !scl_s_ff && scl_d_ff;
  wire start = scl_s_ff && sda_d_ff && !sda_s_ff;
  wire stop = scl_s_ff && !sda_d_ff && sda_s_ff;
  wire [1:0] rd_idx = (st_ff == PRX_ACK_RX) ? 2'h0 : 2'(wb_ff + 2'h1);
  wire [4:0] rd_pos = 5'h18 - {rd_idx, 3'h0};
  wire [7:0] rd_byte = rdata_ff[rd_pos +: 8];
  wire [15:0] adr_inc = adr_ff + `PRX_WORD_STEP;

  always_comb begin
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_oe = oe_n_ff;
    nxt_rw = rw_ff;
    nxt_ph = ph_ff;
    nxt_wb = wb_ff;
    nxt_adr = adr_ff;
    nxt_wd = wd_ff;
    nxt_req = req_ff;
    nxt_tgl = tgl_ff;
    if (start) begin
      nxt_st = PRX_RECV;
      nxt_bit = 4'h0;
      nxt_ph = 2'h0;
      nxt_oe = 1'b1;
    end else if (stop) begin
      nxt_st = PRX_IDLE;
      nxt_oe = 1'b1;
    end else begin
      unique case (st_ff)
        PRX_IDLE: begin
        end
        PRX_RECV: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_s_ff};
            nxt_bit = 4'(bit_ff + 4'h1);
          end else if (scl_fall && bit_ff == 4'h8) begin
            nxt_st = PRX_ACK_RX;
            nxt_oe = 1'b0;
            nxt_bit = 4'h0;
            unique case (ph_ff)
              2'h0: begin
                if (sh_ff[7:1] != DEV_ADDR) begin
                  nxt_st = PRX_IDLE;
                  nxt_oe = 1'b1;
                end else begin
                  nxt_rw = sh_ff[0];
                  nxt_ph = 2'h1;
                  if (sh_ff[0]) begin
                    nxt_req = '{wr: 1'b0, addr: adr_ff, data: 32'h0};
                    nxt_tgl = ~tgl_ff;
                    nxt_adr = adr_inc;
                  end
                end
              end
              2'h1: begin
                nxt_adr[15:8] = sh_ff;
                nxt_ph = 2'h2;
              end
              2'h2: begin
                nxt_adr[7:0] = sh_ff;
                nxt_ph = 2'h3;
                nxt_wb = 2'h0;
              end
              2'h3: begin
                nxt_wd = {wd_ff[23:0], sh_ff};
                nxt_wb = 2'(wb_ff + 2'h1);
                if (wb_ff == 2'h3) begin
                  nxt_req = '{wr: 1'b1, addr: adr_ff, data: nxt_wd};
                  nxt_tgl = ~tgl_ff;
                  nxt_adr = adr_inc;
                end
              end
            endcase
          end
        end
        PRX_ACK_RX: begin
          if (scl_fall && rw_ff) begin
            nxt_st = PRX_SEND;
            nxt_oe = rd_byte[7];
            nxt_sh = {rd_byte[6:0], 1'b0};
            nxt_bit = 4'h1;
            nxt_wb = 2'h0;
          end else if (scl_fall) begin
            nxt_st = PRX_RECV;
            nxt_oe = 1'b1;
          end
        end
        PRX_SEND: begin
          if (scl_fall && bit_ff == 4'h8) begin
            nxt_oe = 1'b1;
            nxt_st = PRX_ACK_TX;
          end else if (scl_fall) begin
            nxt_oe = sh_ff[7];
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_bit = 4'(bit_ff + 4'h1);
          end
        end
        PRX_ACK_TX: begin
          if (scl_rise && sda_s_ff) begin
            nxt_st = PRX_IDLE;
          end else if (scl_rise && wb_ff == 2'h3) begin
            // Next word fetched only once the master asks for it
            nxt_req = '{wr: 1'b0, addr: adr_ff, data: 32'h0};
            nxt_tgl = ~tgl_ff;
            nxt_adr = adr_inc;
          end else if (scl_fall) begin
            nxt_st = PRX_SEND;
            nxt_oe = rd_byte[7];
            nxt_sh = {rd_byte[6:0], 1'b0};
            nxt_bit = 4'h1;
            nxt_wb = 2'(wb_ff + 2'h1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
      st_ff <= PRX_IDLE;
      {bit_ff, sh_ff, oe_n_ff, rw_ff, tgl_ff} <= 15'h0004;
      {ph_ff, wb_ff, adr_ff, wd_ff} <= 52'h0;
      req_ff <= '0;
    end else begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= {SCL, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_d_ff} <= {SDA_IN, sda_m_ff, sda_s_ff};
      st_ff <= nxt_st;
      {bit_ff, sh_ff, oe_n_ff, rw_ff, tgl_ff} <=
        {nxt_bit, nxt_sh, nxt_oe, nxt_rw, nxt_tgl};
      {ph_ff, wb_ff, adr_ff, wd_ff} <= {nxt_ph, nxt_wb, nxt_adr, nxt_wd};
      req_ff <= nxt_req;
    end
  end
  assign SDA_OE_N = oe_n_ff;

  // Core side: flags, events, registers
  logic tg_m_ff, tg_s_ff, tg_d_ff, sda_o_ff;
  logic [PHASES-1:0] prox_ff, body_ff, tbl_ff, sat_ff, comp_ff, done_ff;
  logic [PHASES-1:0] prox_d_ff, body_d_ff, tbl_d_ff, sat_d_ff, scan_ff;
  logic [1:0] bcnt_ff [PHASES];
  logic [1:0] tcnt_ff [PHASES];
  logic conv_ff, csd_ff, irq_n_ff;
  logic [1:0] sel2_ff, sel0_ff, f0_ff;
  logic [10:0] sp_ff;
  logic [7:0] src_ff;
  logic [3:0] ph0_cnt_ff;

  wire take = tg_s_ff ^ tg_d_ff;
  wire [15:0] ra = req_ff.addr;
  wire wr_evcfg = take && req_ff.wr && ra == `PRX_OFS_EVCFG;
  wire wr_scan = take && req_ff.wr && ra == `PRX_OFS_SCAN;
  wire rd_evsrc = take && !req_ff.wr && ra == `PRX_OFS_EVSRC;
  wire any_prox = |prox_ff;
  wire [31:0] stat0 = (32'(prox_ff) << `PRX_PROX_LSB)
    | (32'(tbl_ff) << `PRX_TBL_LSB) | (32'(body_ff) << `PRX_BODY_LSB);
  wire [31:0] stat1 = (32'(comp_ff) << `PRX_COMP_LSB)
    | (32'(sat_ff) << `PRX_SAT_LSB) | (32'(conv_ff) << `PRX_CONV_BIT)
    | (32'(any_prox) << `PRX_ANY_BIT);
  // Only defined fields are stored; the rest reads zero
  wire [31:0] evcfg = (32'(csd_ff) << `PRX_CSD_BIT)
    | (32'(sel2_ff) << `PRX_EV2_LSB) | (32'(sel0_ff) << `PRX_EV0_LSB);
  wire [31:0] scan_w = (32'(f0_ff) << `PRX_F0_LSB)
    | (32'(sp_ff) << `PRX_SP_LSB);
  wire [31:0] rd_word =
    (ra == `PRX_OFS_EVSRC) ? {24'h0, src_ff} :
    (ra == `PRX_OFS_INFO) ? {16'h0, CHIP_ID, CHIP_REV} :
    (ra == `PRX_OFS_STAT0) ? stat0 :
    (ra == `PRX_OFS_STAT1) ? stat1 :
    (ra == `PRX_OFS_EVCFG) ? evcfg :
    (ra == `PRX_OFS_SCAN) ? scan_w : 32'h0;

  // Compensation pending held when offset saturated and the disable bit is set
  wire [PHASES-1:0] comp_clr = COMP_DONE & ~(csd_ff ? OFFSET_SAT : '0);
  wire [PHASES-1:0] nxt_comp = (comp_ff & ~comp_clr) | COMP_START;
  wire ev_comp = |(comp_ff & ~nxt_comp);

  wire [3:0] f0_mask = (f0_ff == 2'h0) ? 4'h0 : (f0_ff == 2'h1) ? 4'h3 :
    (f0_ff == 2'h2) ? 4'h7 : 4'hF;
  wire ph0_due = (ph0_cnt_ff & f0_mask) == 4'h0;
  wire [PHASES-1:0] scan_set = PHASE_EN & ~PHASES'(!ph0_due);
  wire [PHASES-1:0] meas_hot = MEAS.valid ? PHASES'(1) << MEAS.phase : '0;
  wire [PHASES-1:0] nxt_done = SCAN_TICK ? '0 : done_ff | meas_hot;
  wire conv_end = conv_ff && !SCAN_TICK && (nxt_done & scan_ff) == scan_ff;
  wire nxt_conv = SCAN_TICK || (conv_ff && !conv_end);

  wire ev_close = |(prox_ff & ~prox_d_ff);
  wire ev_far = |(~prox_ff & prox_d_ff);
  wire bt_edge = |((body_ff ^ body_d_ff) | (tbl_ff ^ tbl_d_ff));
  wire sat_edge = |(sat_ff ^ sat_d_ff);
  // Reserved select codes raise nothing
  wire ev2 = (sel2_ff == `PRX_SEL_EV2_BT && bt_edge)
    || (sel2_ff == `PRX_SEL_EV2_CONV && conv_end);
  wire ev0 = sel0_ff == `PRX_SEL_EV0_SAT && sat_edge;
  wire [7:0] ev_set = {1'b0, ev_close, ev_far, ev_comp, conv_end,
    ev2, 1'b0, ev0};
  // New events win over the read-clear
  wire [7:0] nxt_src = (src_ff & ~{8{rd_evsrc}}) | ev_set;

  for (genvar i = 0; i < PHASES; i++) begin : g_ph
    wire hit = MEAS.valid && MEAS.phase == 3'(i);
    wire [16:0] d = {1'b0, MEAS.delta};
    wire [16:0] dh = d + 17'(LIMITS[i].hyst);
    wire prox_n = d > {1'b0, LIMITS[i].prox};
    wire b_cl = d > {1'b0, LIMITS[i].body} + 17'(LIMITS[i].hyst);
    wire b_far = dh < {1'b0, LIMITS[i].body};
    wire t_cl = d > {1'b0, LIMITS[i].tbl} + 17'(LIMITS[i].hyst);
    wire t_far = dh < {1'b0, LIMITS[i].tbl};
    // Hysteresis and debounce for body and table
    wire [2:0] b_n = deb_step(body_ff[i], bcnt_ff[i], b_cl, b_far,
      LIMITS[i].deb);
    wire [2:0] t_n = deb_step(tbl_ff[i], tcnt_ff[i], t_cl, t_far,
      LIMITS[i].deb);
    always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        {prox_ff[i], body_ff[i], tbl_ff[i], sat_ff[i]} <= 4'h0;
        {bcnt_ff[i], tcnt_ff[i]} <= 4'h0;
      end else if (hit) begin
        prox_ff[i] <= prox_n;
        // Body and table forced low without proximity
        body_ff[i] <= b_n[2] && prox_n;
        tbl_ff[i] <= t_n[2] && prox_n;
        bcnt_ff[i] <= prox_n ? b_n[1:0] : 2'h0;
        tcnt_ff[i] <= prox_n ? t_n[1:0] : 2'h0;
        // Frozen while sensing is off
        if (SAT_EN) begin
          sat_ff[i] <= MEAS.useful > LIMITS[i].sat;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      {tg_m_ff, tg_s_ff, tg_d_ff, sda_o_ff, irq_n_ff} <= 5'h00;
      {prox_d_ff, body_d_ff, tbl_d_ff, sat_d_ff} <= '0;
      {comp_ff, done_ff, scan_ff, conv_ff} <= '0;
      {csd_ff, sel2_ff, sel0_ff, f0_ff} <= 7'h00;
      sp_ff <= `PRX_SP_RST;
      src_ff <= `PRX_EVSRC_RST;
      ph0_cnt_ff <= 4'h0;
      rdata_ff <= 32'h0;
    end else begin
      {tg_m_ff, tg_s_ff, tg_d_ff} <= {tgl_ff, tg_m_ff, tg_s_ff};
      {prox_d_ff, body_d_ff, tbl_d_ff, sat_d_ff} <=
        {prox_ff, body_ff, tbl_ff, sat_ff};
      {comp_ff, done_ff, conv_ff} <= {nxt_comp, nxt_done, nxt_conv};
      src_ff <= nxt_src;
      irq_n_ff <= ~|src_ff;
      if (SCAN_TICK) begin
        scan_ff <= scan_set;
        ph0_cnt_ff <= 4'(ph0_cnt_ff + 4'h1);
      end
      if (take && !req_ff.wr) begin
        rdata_ff <= rd_word;
      end
      if (wr_evcfg) begin
        csd_ff <= req_ff.data[`PRX_CSD_BIT];
        sel2_ff <= req_ff.data[`PRX_EV2_LSB +: 2];
        sel0_ff <= req_ff.data[`PRX_EV0_LSB +: 2];
      end
      if (wr_scan) begin
        f0_ff <= req_ff.data[`PRX_F0_LSB +: 2];
        sp_ff <= req_ff.data[`PRX_SP_LSB +: 11];
      end
    end
  end
  assign HOST_INTERRUPT_PIN_N = irq_n_ff;
  assign SCAN_PHASES = scan_ff;
  assign SDA_OUT = sda_o_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n_ff);
  sequence s_ack;
    rd_evsrc && ev_set == 8'h00;
  endsequence
  sequence s_scan_start;
    SCAN_TICK ##1 conv_ff;
  endsequence

  chk_table_gated: assert property ((tbl_ff & ~prox_ff) == '0)
    else $error("table flag without proximity");
  chk_body_gated: assert property ((body_ff & ~prox_ff) == '0)
    else $error("body flag without proximity");
  chk_prox_set: assert property (MEAS.valid
    && MEAS.delta > LIMITS[MEAS.phase].prox |=> prox_ff[$past(MEAS.phase)])
    else $error("proximity flag not set");
  chk_any_read: assert property (take && ra == `PRX_OFS_STAT1
    |=> rdata_ff[`PRX_ANY_BIT] == $past(any_prox))
    else $error("any proximity bit wrong");
  chk_conv_span: assert property (s_scan_start |->
    conv_ff until_with (conv_end || SCAN_TICK))
    else $error("conversion flag dropped early");
  chk_sat_frozen: assert property (!SAT_EN |=> $stable(sat_ff))
    else $error("saturation flag changed while disabled");
  chk_sat_set: assert property (MEAS.valid && SAT_EN
    && MEAS.useful > LIMITS[MEAS.phase].sat |=> sat_ff[$past(MEAS.phase)])
    else $error("saturation flag not set");
  chk_comp_pend: assert property (|COMP_START |=>
    (comp_ff & $past(COMP_START)) == $past(COMP_START))
    else $error("compensation pending not set");
  chk_comp_hold: assert property (csd_ff
    && (COMP_DONE & ~OFFSET_SAT) == '0 |=> (comp_ff & $past(comp_ff))
    == $past(comp_ff)
    && src_ff[4] == ($past(src_ff[4]) && !$past(rd_evsrc)))
    else $error("saturated compensation cleared");
  chk_evsrc_clear: assert property (s_ack |=> src_ff == 8'h00
    ##1 HOST_INTERRUPT_PIN_N)
    else $error("event source not cleared on read");
  chk_close_event: assert property (ev_close |=> src_ff[6])
    else $error("close event missing");
  chk_ph0_skip: assert property (SCAN_TICK && f0_ff == 2'h1
    && ph0_cnt_ff[1:0] != 2'h0 |=> !SCAN_PHASES[0])
    else $error("phase zero scanned off cadence");
  chk_ev0_sat: assert property (sel0_ff == 2'h2 && sat_edge
    |=> src_ff[0])
    else $error("event zero missing on saturation edge");
  chk_ev2_conv: assert property (sel2_ff == 2'h2 && conv_end
    |=> src_ff[2] && src_ff[3])
    else $error("event two missing on conversion end");
  chk_cfg_reserved: assert property (take && !req_ff.wr
    && ra == `PRX_OFS_EVCFG |=> (rdata_ff & 32'hFF8CFFFF) == 32'h0)
    else $error("reserved config bits not zero");
endmodule

// ==== sim/prx_host_model.sv ====
// Purpose: Host side serial master for the status block
// Assumes: Data line is resolved with a pull-up by the bench
// Notes: Quarter-bit timing, no clock stretching expected
`timescale 1ns/1ps
`include "prx_consts.svh"
module prx_host_model #(
  parameter int QTR = 640
) (
  output logic SCL,
  output logic SDA_LOW,
  input wire logic SDA
);
  initial begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
  end
  // Data changes only while the clock is low
  task automatic bt(input logic b, output logic r);
    SDA_LOW = ~b;
    #QTR SCL = 1'b1;
    #QTR r = SDA;
    #QTR SCL = 1'b0;
    #QTR;
  endtask
  task automatic start();
    SDA_LOW = 1'b0;
    #QTR SCL = 1'b1;
    #QTR SDA_LOW = 1'b1;
    #QTR SCL = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    SDA_LOW = 1'b1;
    #QTR SCL = 1'b1;
    #QTR SDA_LOW = 1'b0;
    #QTR;
  endtask
  task automatic tx(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bt(v[i], r);
    bt(1'b1, r);
    ok &= ~r;
  endtask
  // Last byte of a read is refused so the device stops sending
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, v[i]);
    bt(last, r);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
      output logic ok);
    ok = 1'b1;
    start();
    tx({`PRX_DEV_ADDR, 1'b0}, ok);
    tx(a[15:8], ok);
    tx(a[7:0], ok);
    for (int i = 3; i >= 0; i--) tx(d[i*8 +: 8], ok);
    stop();
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
      output logic ok);
    ok = 1'b1;
    start();
    tx({`PRX_DEV_ADDR, 1'b0}, ok);
    tx(a[15:8], ok);
    tx(a[7:0], ok);
    start();
    tx({`PRX_DEV_ADDR, 1'b1}, ok);
    for (int i = 3; i >= 0; i--) rx(i == 0, d[i*8 +: 8]);
    stop();
  endtask
endmodule

// ==== sim/prx_status_tb.sv ====
// Purpose: Self-checking bench for the status block
// Assumes: Host model on the serial pins, front end driven here
// Notes: Seeded random limits and config values
`timescale 1ns/1ps
`include "prx_consts.svh"
module prx_status_tb;
  import prx_pkg::*;
  // Identity values are arbitrary
  localparam logic [7:0] ID = 8'h5C;
  localparam logic [7:0] REV = 8'h03;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic scl, sda_low, sda_out, sda_oe_n, irq_n, sat_en, scan_tick, ok;
  logic [5:0] scan_ph, phase_en, comp_start, comp_done, offset_sat;
  logic [15:0] d2;
  logic [31:0] rv;
  prx_meas_s meas;
  prx_limit_s lim;
  prx_limit_s [5:0] limits;
  wire sda = ~sda_low & (sda_oe_n | sda_out);
  integer seed = 32;
  int fail_count = 0;
  int n_compared = 0;
  int cnt;
  initial forever #25 clk = ~clk;
  initial begin
    #37;
    forever #80 lclk = ~lclk;
  end
  prx_status #(.CHIP_ID(ID), .CHIP_REV(REV)) prx_status_i (
    .CLK(clk), .NRST(nrst), .LINK_CLK(lclk), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .HOST_INTERRUPT_PIN_N(irq_n),
    .SCAN_PHASES(scan_ph), .MEAS(meas), .LIMITS(limits), .SAT_EN(sat_en),
    .SCAN_TICK(scan_tick), .PHASE_EN(phase_en), .COMP_START(comp_start),
    .COMP_DONE(comp_done), .OFFSET_SAT(offset_sat));
  prx_host_model prx_host_model_i (.SCL(scl), .SDA_LOW(sda_low),
    .SDA(sda));
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  function automatic logic [31:0] f_stat0(logic [5:0] pr, tb, bd);
    return {2'h0, pr, 2'h0, tb, 2'h0, bd, 8'h00};
  endfunction
  function automatic logic [31:0] f_stat1(logic [5:0] cp, st,
      logic cv, an);
    return {10'h000, cp, 2'h0, st, cv, 6'h00, an};
  endfunction
  function automatic logic [31:0] f_cfg(logic [31:0] v);
    return v & 32'h00730000;
  endfunction
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  task automatic reg_chk(input logic [15:0] a, input logic [31:0] e,
      input string nm);
    prx_host_model_i.rd(a, rv, ok);
    chk_bit("ack", 1'b1, ok);
    chk_word(nm, e, rv);
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    prx_host_model_i.wr(a, d, ok);
    chk_bit("ack", 1'b1, ok);
  endtask
  task automatic tick();
    step();
    scan_tick = 1'b1;
    step();
    scan_tick = 1'b0;
  endtask
  task automatic put(input logic [2:0] p, input logic [15:0] d, u);
    step();
    meas = '{1'b1, p, d, u};
    step();
    meas.valid = 1'b0;
  endtask
  task automatic scan(input logic [15:0] dp, up);
    tick();
    for (int p = 0; p < 6; p++)
      put(3'(p), p == 2 ? dp : 16'h0000, p == 4 ? up : 16'h0000);
    repeat (4) step();
  endtask
  task automatic pin_chk(input logic e);
    for (int i = 0; i < 20 && irq_n !== e; i++) step();
    chk_bit("irq pin", e, irq_n);
  endtask
  task automatic ph0_count(input int n, input int e);
    cnt = 0;
    repeat (n) begin
      tick();
      cnt += int'(scan_ph[0] === 1'b1);
      chk_bit("phases 5:1", 1'b1, &scan_ph[5:1]);
    end
    chk_word("phase0 scans", 32'(e), 32'(cnt));
  endtask
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial begin
    meas = '0;
    sat_en = 1'b1;
    scan_tick = 1'b0;
    phase_en = 6'h3F;
    comp_start = 6'h00;
    comp_done = 6'h00;
    offset_sat = 6'h00;
    lim = '0;
    lim.prox = 16'(100 + {$random(seed)} % 1000);
    lim.body = lim.prox + 16'h0032;
    lim.tbl = lim.prox + 16'h0020;
    lim.sat = 16'h8000;
    lim.hyst = 8'h0A;
    limits = {6{lim}};
    d2 = lim.body + 16'h0015 + 16'({$random(seed)} % 100);
    repeat (8) @(posedge clk);
    #2 nrst = 1'b1;
    pin_chk(1'b0);
    repeat (20) step();
    reg_chk(`PRX_OFS_EVSRC, 32'h00000080, "event source");
    pin_chk(1'b1);
    reg_chk(`PRX_OFS_INFO, {16'h0000, ID, REV}, "chip info");
    reg_chk(`PRX_OFS_SCAN, 32'h00000032, "scan reset");
    reg_chk(16'h8008, 32'h00000000, "unmapped");
    rv = $random(seed);
    reg_wr(`PRX_OFS_EVCFG, rv);
    reg_chk(`PRX_OFS_EVCFG, f_cfg(rv), "event config");
    $display("Test registers done");
    ph0_count(4, 4);
    reg_wr(`PRX_OFS_SCAN, 32'h40000032);
    ph0_count(8, 2);
    reg_chk(`PRX_OFS_SCAN, 32'h40000032, "scan config");
    reg_chk(`PRX_OFS_STAT1, f_stat1(6'h00, 6'h00, 1'b1, 1'b0),
      "conv active");
    $display("Test scan multiplier done");
    reg_wr(`PRX_OFS_EVCFG, 32'h00620000);
    scan(d2, 16'h9000);
    sat_en = 1'b0;
    scan(d2, 16'h0000);
    comp_start = 6'h0A;
    step();
    comp_start = 6'h00;
    offset_sat = 6'h02;
    comp_done = 6'h02;
    step();
    comp_done = 6'h08;
    step();
    comp_done = 6'h00;
    reg_chk(`PRX_OFS_STAT0, f_stat0(6'h04, 6'h04, 6'h04),
      "status 0");
    reg_chk(`PRX_OFS_STAT1, f_stat1(6'h02, 6'h10, 1'b0, 1'b1),
      "status 1");
    pin_chk(1'b0);
    reg_chk(`PRX_OFS_EVSRC, 32'h0000005D, "event source");
    pin_chk(1'b1);
    $display("Test flags and events done");
    reg_wr(`PRX_OFS_EVCFG, 32'h00420000);
    put(3'h2, 16'h0000, 16'h0000);
    pin_chk(1'b0);
    reg_chk(`PRX_OFS_EVSRC, 32'h00000024, "far event");
    $display("Test far event done");
    end_sim();
  end
endmodule
